// [cdm_pkg.sv]
// Constants, register map and state type of the carrier/data modulator.
// Assumes a 32-bit AXI4-Lite slave on clk_sys; byte address = 4 x register index.
// Contract
// - The high-time carrier selector decodes pin, system clock, fast oscillator, reference clock, capture/compare 1-5, pulse-width 6-7, codes 11-15 reserved.
// - The low-time carrier selector is a separate field with the same source encoding.
// - With synchronization on, the carrier pulse in use at a modulator transition falls low before the switch.
// - High and low carrier synchronization are enabled by two independent control bits.
// - With the high wait bit set, the switch from high to low carrier waits for the high carrier to fall.
// - Each selected carrier is inverted when its own polarity bit is set.
// - The output invert bit inverts the modulated output, making its idle level high while enabled; with enable clear the output stays low.
// - The enable bit turns mixing on; when clear the block produces no modulated output.
// - Bit 5 of the main control register reads back the present output value.
// - Bit 0 of the main control register is a software modulator, used only when selected as source.
// - Any reset disables the block and returns every register to its default.
// - While the power-down input is set the block is disabled and its registers held at reset values.
// - The mixing path is clocked: synchronisers, carrier state and the output register all run on clk_sys, so it needs that clock.
// - The output is a carrier picked by the modulator: high carrier while modulator high, else low carrier.
// - Clearing enable forces the output low and keeps all selections; setting it resumes modulation.
// - The modulator source is a 5-bit selector: pin, software bit, peripheral outputs, 24-31 reserved.
package cdm_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices (byte address is four times these)
  localparam logic [13:0] IDX_MAIN = 14'h0f51;
  localparam logic [13:0] IDX_SYNC = 14'h0f52;
  localparam logic [13:0] IDX_SRC = 14'h0f53;
  localparam logic [13:0] IDX_LOSEL = 14'h0f54;
  localparam logic [13:0] IDX_HISEL = 14'h0f55;

  // ==========================================================================
  // Field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_OUT = 5;
  localparam int BIT_OUT_INV = 4;
  localparam int BIT_SOFT_MOD = 0;
  localparam int BIT_HI_INV = 5;
  localparam int BIT_HI_WAIT = 4;
  localparam int BIT_LO_INV = 1;
  localparam int BIT_LO_WAIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [4:0] RST_SRC = 5'h00;
  localparam logic [3:0] RST_CARSEL = 4'h0;

  // ==========================================================================
  // Source codes
  localparam logic [3:0] CAR_PIN = 4'h0;
  localparam logic [3:0] CAR_SYSCLK = 4'h1;
  localparam logic [3:0] CAR_FASTOSC = 4'h2;
  localparam logic [3:0] CAR_REFCLK = 4'h3;
  localparam logic [3:0] CAR_CCP_FIRST = 4'h4;
  localparam logic [3:0] CAR_PWM_FIRST = 4'h9;
  localparam logic [3:0] CAR_RESERVED = 4'hb;
  localparam logic [4:0] MOD_PIN = 5'h00;
  localparam logic [4:0] MOD_SOFT = 5'h01;
  localparam logic [4:0] MOD_CCP_FIRST = 5'h02;
  localparam logic [4:0] MOD_PWM_FIRST = 5'h07;
  localparam logic [4:0] MOD_CMP_FIRST = 5'h09;
  localparam logic [4:0] MOD_UART_FIRST = 5'h0c;
  localparam logic [4:0] MOD_SPI_FIRST = 5'h16;
  localparam logic [4:0] MOD_RESERVED = 5'h18;

  // ==========================================================================
  // Carrier in use
  typedef enum logic [1:0] {
    CDM_USE_LO = 2'b01,
    CDM_USE_HI = 2'b10
  } cdm_carrier_t;

endpackage

// [cdm_sync2.sv]
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a clock-like wave sampled on clk_sys.
`timescale 1ns/100ps
module cdm_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

// [cdm_mixer.sv]
// Carrier/data modulator: source muxes, carrier switch-over and AXI4-Lite registers.
// Assumes peripheral outputs are on clk_sys; pins and foreign clocks arrive raw.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
module cdm_mixer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Power management
  input wire logic mixerPowerDown,
  // Raw pins and foreign clocks
  input wire logic modulatorPin,
  input wire logic hiCarrierPin,
  input wire logic loCarrierPin,
  input wire logic systemClockSrc,
  input wire logic fastInternalOsc,
  input wire logic referenceClockOut,
  // Peripheral outputs on clk_sys
  input wire logic [4:0] ccpOut,
  input wire logic [1:0] pwmOut,
  input wire logic [2:0] cmpOut,
  input wire logic [4:0] uartRxOut,
  input wire logic [4:0] uartTxOut,
  input wire logic [1:0] spiSdoOut,
  // Modulated output
  output logic modulatedOutputPin,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [cdm_pkg::ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [cdm_pkg::ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ==========================================================================
  // Declarations
  logic [5:0] pinSync;
  logic modPinS, hiPinS, loPinS, sysClkS, fastOscS, refClkS;
  logic ctrlEnable, outputInvert, softModulatorValue;
  logic hiCarrierInvert, hiCarrierWaitEn, loCarrierInvert, loCarrierWaitEn;
  logic [4:0] modulatorSourceSel;
  logic [3:0] loCarrierSel, hiCarrierSel;
  logic awHeld, wHeld;
  logic [cdm_pkg::ADDR_W-1:0] awAddrHeld;
  logic [7:0] wDataHeld;
  logic wLane0Held;
  logic doWrite, wrHit, rdHit;
  logic [13:0] wrIdx, rdIdx;
  logic [7:0] rdByte;
  logic modSig, hiRaw, loRaw, hiCar, loCar, mixed;
  cdm_pkg::cdm_carrier_t carState, next_carState;

  // ==========================================================================
  // Input synchronisers
  cdm_sync2 #(
    .W(6)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .din({modulatorPin, hiCarrierPin, loCarrierPin, systemClockSrc, fastInternalOsc,
          referenceClockOut}),
    .dout(pinSync)
  );
  assign {modPinS, hiPinS, loPinS, sysClkS, fastOscS, refClkS} = pinSync;

  // ==========================================================================
  // Carrier and modulator source selection
  // Sampled clocks above 125 MHz alias; such sources only make sense when slow.
  function automatic logic pickCarrier(input logic [3:0] sel, input logic pinLvl);
    logic v;
    v = 1'b0;
    if (sel == cdm_pkg::CAR_PIN) begin
      v = pinLvl;
    end else if (sel == cdm_pkg::CAR_SYSCLK) begin
      v = sysClkS;
    end else if (sel == cdm_pkg::CAR_FASTOSC) begin
      v = fastOscS;
    end else if (sel == cdm_pkg::CAR_REFCLK) begin
      v = refClkS;
    end else if (sel < cdm_pkg::CAR_PWM_FIRST) begin
      v = ccpOut[3'(sel - cdm_pkg::CAR_CCP_FIRST)];
    end else if (sel < cdm_pkg::CAR_RESERVED) begin
      v = pwmOut[1'(sel - cdm_pkg::CAR_PWM_FIRST)];
    end
    return v;
  endfunction

  // Process form, so that sources read inside the function also wake it up
  always_comb begin
    hiRaw = pickCarrier(hiCarrierSel, hiPinS);
  end

  always_comb begin
    loRaw = pickCarrier(loCarrierSel, loPinS);
  end

  assign hiCar = hiRaw ^ hiCarrierInvert;
  assign loCar = loRaw ^ loCarrierInvert;

  always_comb begin
    modSig = 1'b0;
    if (modulatorSourceSel == cdm_pkg::MOD_PIN) begin
      modSig = modPinS;
    end else if (modulatorSourceSel == cdm_pkg::MOD_SOFT) begin
      modSig = softModulatorValue;
    end else if (modulatorSourceSel < cdm_pkg::MOD_PWM_FIRST) begin
      modSig = ccpOut[3'(modulatorSourceSel - cdm_pkg::MOD_CCP_FIRST)];
    end else if (modulatorSourceSel < cdm_pkg::MOD_CMP_FIRST) begin
      modSig = pwmOut[1'(modulatorSourceSel - cdm_pkg::MOD_PWM_FIRST)];
    end else if (modulatorSourceSel < cdm_pkg::MOD_UART_FIRST) begin
      modSig = cmpOut[2'(modulatorSourceSel - cdm_pkg::MOD_CMP_FIRST)];
    end else if (modulatorSourceSel < cdm_pkg::MOD_SPI_FIRST) begin
      // Receive and transmit of one port sit on adjacent codes
      if (modulatorSourceSel[0]) begin
        modSig = uartTxOut[3'((modulatorSourceSel - cdm_pkg::MOD_UART_FIRST) >> 1)];
      end else begin
        modSig = uartRxOut[3'((modulatorSourceSel - cdm_pkg::MOD_UART_FIRST) >> 1)];
      end
    end else if (modulatorSourceSel < cdm_pkg::MOD_RESERVED) begin
      modSig = spiSdoOut[1'(modulatorSourceSel - cdm_pkg::MOD_SPI_FIRST)];
    end
  end

  // ==========================================================================
  // Carrier switch-over
  // The switch waits only while the pulse in use is still high, so a carrier
  // parked low never blocks the modulator.
  always_comb begin
    next_carState = carState;
    unique case (carState)
      cdm_pkg::CDM_USE_HI: begin
        if (!modSig && (!hiCarrierWaitEn || !hiCar)) begin
          next_carState = cdm_pkg::CDM_USE_LO;
        end
      end
      cdm_pkg::CDM_USE_LO: begin
        if (modSig && (!loCarrierWaitEn || !loCar)) begin
          next_carState = cdm_pkg::CDM_USE_HI;
        end
      end
      default: next_carState = cdm_pkg::CDM_USE_LO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      carState <= cdm_pkg::CDM_USE_LO;
    end else if (mixerPowerDown) begin
      carState <= cdm_pkg::CDM_USE_LO;
    end else begin
      carState <= next_carState;
    end
  end

  // Function of the sources and the carrier state, no clock gating or sleep input involved
  assign mixed = (next_carState == cdm_pkg::CDM_USE_HI) ? hiCar : loCar;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      modulatedOutputPin <= 1'b0;
    end else if (ctrlEnable && !mixerPowerDown) begin
      modulatedOutputPin <= mixed ^ outputInvert;
    end else begin
      modulatedOutputPin <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign wrIdx = awAddrHeld[15:2];
  assign wrHit = (wrIdx >= cdm_pkg::IDX_MAIN) && (wrIdx <= cdm_pkg::IDX_HISEL);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      awAddrHeld <= '0;
    end else if (awvalid && awready) begin
      awHeld <= 1'b1;
      awAddrHeld <= awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wHeld <= 1'b0;
      wDataHeld <= 8'h00;
      wLane0Held <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld <= 1'b1;
      wDataHeld <= wdata[7:0];
      wLane0Held <= wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= cdm_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= wrHit ? cdm_pkg::RESP_OKAY : cdm_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Register file
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {ctrlEnable, outputInvert, softModulatorValue} <= '0;
      {hiCarrierInvert, hiCarrierWaitEn, loCarrierInvert, loCarrierWaitEn} <= '0;
      modulatorSourceSel <= cdm_pkg::RST_SRC;
      loCarrierSel <= cdm_pkg::RST_CARSEL;
      hiCarrierSel <= cdm_pkg::RST_CARSEL;
    end else if (mixerPowerDown) begin
      ctrlEnable <= cdm_pkg::RST_MAIN[cdm_pkg::BIT_ENABLE];
      outputInvert <= cdm_pkg::RST_MAIN[cdm_pkg::BIT_OUT_INV];
      softModulatorValue <= cdm_pkg::RST_MAIN[cdm_pkg::BIT_SOFT_MOD];
      hiCarrierInvert <= cdm_pkg::RST_SYNC[cdm_pkg::BIT_HI_INV];
      hiCarrierWaitEn <= cdm_pkg::RST_SYNC[cdm_pkg::BIT_HI_WAIT];
      loCarrierInvert <= cdm_pkg::RST_SYNC[cdm_pkg::BIT_LO_INV];
      loCarrierWaitEn <= cdm_pkg::RST_SYNC[cdm_pkg::BIT_LO_WAIT];
      modulatorSourceSel <= cdm_pkg::RST_SRC;
      loCarrierSel <= cdm_pkg::RST_CARSEL;
      hiCarrierSel <= cdm_pkg::RST_CARSEL;
    end else if (doWrite && wLane0Held) begin
      // Output status bit is not writable; selections survive enable changes
      if (wrIdx == cdm_pkg::IDX_MAIN) begin
        ctrlEnable <= wDataHeld[cdm_pkg::BIT_ENABLE];
        outputInvert <= wDataHeld[cdm_pkg::BIT_OUT_INV];
        softModulatorValue <= wDataHeld[cdm_pkg::BIT_SOFT_MOD];
      end
      if (wrIdx == cdm_pkg::IDX_SYNC) begin
        hiCarrierInvert <= wDataHeld[cdm_pkg::BIT_HI_INV];
        hiCarrierWaitEn <= wDataHeld[cdm_pkg::BIT_HI_WAIT];
        loCarrierInvert <= wDataHeld[cdm_pkg::BIT_LO_INV];
        loCarrierWaitEn <= wDataHeld[cdm_pkg::BIT_LO_WAIT];
      end
      if (wrIdx == cdm_pkg::IDX_SRC) begin
        modulatorSourceSel <= wDataHeld[4:0];
      end
      if (wrIdx == cdm_pkg::IDX_LOSEL) begin
        loCarrierSel <= wDataHeld[3:0];
      end
      if (wrIdx == cdm_pkg::IDX_HISEL) begin
        hiCarrierSel <= wDataHeld[3:0];
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  assign arready = !rvalid;
  assign rdIdx = araddr[15:2];
  assign rdHit = (rdIdx >= cdm_pkg::IDX_MAIN) && (rdIdx <= cdm_pkg::IDX_HISEL);

  always_comb begin
    rdByte = 8'h00;
    if (rdIdx == cdm_pkg::IDX_MAIN) begin
      rdByte[cdm_pkg::BIT_ENABLE] = ctrlEnable;
      rdByte[cdm_pkg::BIT_OUT] = modulatedOutputPin;
      rdByte[cdm_pkg::BIT_OUT_INV] = outputInvert;
      rdByte[cdm_pkg::BIT_SOFT_MOD] = softModulatorValue;
    end else if (rdIdx == cdm_pkg::IDX_SYNC) begin
      rdByte[cdm_pkg::BIT_HI_INV] = hiCarrierInvert;
      rdByte[cdm_pkg::BIT_HI_WAIT] = hiCarrierWaitEn;
      rdByte[cdm_pkg::BIT_LO_INV] = loCarrierInvert;
      rdByte[cdm_pkg::BIT_LO_WAIT] = loCarrierWaitEn;
    end else if (rdIdx == cdm_pkg::IDX_SRC) begin
      rdByte[4:0] = modulatorSourceSel;
    end else if (rdIdx == cdm_pkg::IDX_LOSEL) begin
      rdByte[3:0] = loCarrierSel;
    end else if (rdIdx == cdm_pkg::IDX_HISEL) begin
      rdByte[3:0] = hiCarrierSel;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= cdm_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rdByte};
      rresp <= rdHit ? cdm_pkg::RESP_OKAY : cdm_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  AST_RESERVED_HI: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (hiCarrierSel >= cdm_pkg::CAR_RESERVED) |-> (hiRaw == 1'b0))
    else $error("reserved high carrier code does not give a quiet carrier");

  AST_LO_FOLLOWS_SEL: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (loCarrierSel == cdm_pkg::CAR_CCP_FIRST) |-> (loRaw == ccpOut[0]))
    else $error("low carrier select does not pick the first compare output");

  AST_MOD_RESERVED: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (modulatorSourceSel >= cdm_pkg::MOD_RESERVED) |-> !modSig)
    else $error("reserved modulator code drives a modulator");

  AST_SOFT_MOD: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (modulatorSourceSel == cdm_pkg::MOD_SOFT) |-> (modSig == softModulatorValue))
    else $error("software modulator bit not used when selected");

  AST_POLARITY: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ((hiCarrierSel != cdm_pkg::CAR_CCP_FIRST) || (hiCar == (ccpOut[0] ^ hiCarrierInvert)))
      && ((loCarrierSel != cdm_pkg::CAR_CCP_FIRST)
      || (loCar == (ccpOut[0] ^ loCarrierInvert))))
    else $error("carrier polarity not applied");

  AST_HI_WAIT: assert property (
    @(posedge clk_sys) disable iff (!resetn || mixerPowerDown)
    (carState == cdm_pkg::CDM_USE_HI && hiCarrierWaitEn && hiCar)
      |=> (carState == cdm_pkg::CDM_USE_HI))
    else $error("left high carrier while its pulse was still high");

  AST_LO_WAIT: assert property (
    @(posedge clk_sys) disable iff (!resetn || mixerPowerDown)
    (carState == cdm_pkg::CDM_USE_LO && loCarrierWaitEn && loCar)
      |=> (carState == cdm_pkg::CDM_USE_LO))
    else $error("left low carrier while its pulse was still high");

  AST_NO_WAIT: assert property (
    @(posedge clk_sys) disable iff (!resetn || mixerPowerDown)
    (carState == cdm_pkg::CDM_USE_HI && !hiCarrierWaitEn && !modSig)
      |=> (carState == cdm_pkg::CDM_USE_LO))
    else $error("switch to low carrier delayed without synchronization");

  AST_OUT_VALUE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ctrlEnable && !mixerPowerDown)
      |=> (modulatedOutputPin == $past(mixed ^ outputInvert)))
    else $error("modulated output does not follow the mixed carrier");

  AST_DISABLED_LOW: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !ctrlEnable |=> !modulatedOutputPin)
    else $error("output not low while disabled");

  AST_POWER_DOWN: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    mixerPowerDown |=> (!ctrlEnable && modulatorSourceSel == cdm_pkg::RST_SRC
      && hiCarrierSel == cdm_pkg::RST_CARSEL && !hiCarrierWaitEn && !modulatedOutputPin))
    else $error("power-down did not clear the block");

  AST_READBACK: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (arvalid && arready && rdIdx == cdm_pkg::IDX_MAIN)
      |=> (rvalid && rdata[cdm_pkg::BIT_OUT] == $past(modulatedOutputPin)))
    else $error("output readback bit wrong");

endmodule

// [cdm_src_model.sv]
// Stand-in for the pins, clocks and same-clock peripherals feeding the mixer.
// Assumes the bench seeds the generator; slow holds each level for 4 cycles.
`timescale 1ns/100ps
module cdm_src_model (
  // Clock and pacing
  input wire logic clk_sys,
  input wire logic slow,
  // Sources: raw = {ref clock, fast osc, sys clock, mod pin, lo pin, hi pin}
  output logic [5:0] raw,
  output logic [4:0] ccpOut,
  output logic [1:0] pwmOut,
  output logic [2:0] cmpOut,
  output logic [4:0] uartRxOut,
  output logic [4:0] uartTxOut,
  output logic [1:0] spiSdoOut
);
  logic [1:0] hold = 2'h0;
  initial {raw, ccpOut, pwmOut, cmpOut, uartRxOut, uartTxOut, spiSdoOut} = 28'h0;
  // ==========================================================================
  // Levels move just after an edge, as a real same-clock peripheral would
  always @(posedge clk_sys) begin
    hold <= slow ? hold + 2'h1 : 2'h0;
    if (hold == 2'h0) begin
      {raw, ccpOut, pwmOut, cmpOut} <= 16'($urandom);
      {uartRxOut, uartTxOut, spiSdoOut} <= 12'($urandom);
    end
  end
endmodule

// [tb.sv]
// Self-checking bench for the carrier/data mixer with a per-cycle reference.
// Assumes cdm_pkg, cdm_mixer and cdm_src_model are compiled before it.
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic pd = 1'b0;
  logic slow = 1'b0;
  logic chk = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, modOut;
  logic [1:0] bresp, rresp, pwmOut, spiSdoOut;
  logic [31:0] rdata;
  logic [5:0] raw, d1 = 6'h0, d2 = 6'h0;
  logic [4:0] ccpOut, uartRxOut, uartTxOut;
  logic [2:0] cmpOut;
  logic [7:0] sh [5];
  logic useHi = 1'b0, curOut = 1'b0;
  logic expOut [$];
  logic [33:0] busQ [$];
  int fail_count = 0, n_checks = 0;
  always #2 clk_sys = ~clk_sys;
  cdm_src_model pm (.clk_sys(clk_sys), .slow(slow), .raw(raw), .ccpOut(ccpOut),
    .pwmOut(pwmOut), .cmpOut(cmpOut), .uartRxOut(uartRxOut), .uartTxOut(uartTxOut),
    .spiSdoOut(spiSdoOut));
  cdm_mixer dut (.clk_sys(clk_sys), .resetn(resetn), .mixerPowerDown(pd),
    .modulatorPin(raw[2]), .hiCarrierPin(raw[0]), .loCarrierPin(raw[1]),
    .systemClockSrc(raw[3]), .fastInternalOsc(raw[4]), .referenceClockOut(raw[5]),
    .ccpOut(ccpOut), .pwmOut(pwmOut), .cmpOut(cmpOut), .uartRxOut(uartRxOut),
    .uartTxOut(uartTxOut), .spiSdoOut(spiSdoOut), .modulatedOutputPin(modOut),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  // ==========================================================================
  // Reference model; pins and foreign clocks arrive two edges late
  function automatic logic carSel(input logic [3:0] c, input logic p);
    logic [10:0] v;
    v = {pwmOut, ccpOut, d2[5:3], p};
    return (c < 4'hb) ? v[c] : 1'b0;
  endfunction
  function automatic logic modSel(input logic [4:0] c);
    logic [31:0] v;
    v = {8'h00, spiSdoOut, 10'h000, cmpOut, pwmOut, ccpOut, sh[0][0], d2[2]};
    for (int k = 0; k < 5; k++) begin
      v[12 + 2 * k] = uartRxOut[k];
      v[13 + 2 * k] = uartTxOut[k];
    end
    return v[c];
  endfunction
  always @(posedge clk_sys) begin : ref_model
    logic m, hc, lc, nu, e;
    m = modSel(sh[2][4:0]);
    hc = carSel(sh[4][3:0], d2[0]) ^ sh[1][5];
    lc = carSel(sh[3][3:0], d2[1]) ^ sh[1][1];
    nu = useHi;
    if (m && !useHi && !(sh[1][0] && lc)) nu = 1'b1;
    if (!m && useHi && !(sh[1][4] && hc)) nu = 1'b0;
    e = sh[0][7] && ((nu ? hc : lc) ^ sh[0][4]);
    if (pd || !resetn) begin
      e = 1'b0;
      nu = 1'b0;
      sh <= '{default: 8'h00};
    end
    useHi <= nu;
    curOut <= e;
    if (chk) expOut.push_back(e);
    d1 <= raw;
    d2 <= d1;
  end
  // ==========================================================================
  // Result watchers
  always @(negedge clk_sys) begin
    if (expOut.size() > 0) begin : out_cmp
      logic e;
      e = expOut.pop_front();
      n_checks++;
      if (modOut !== e) begin
        $display("BAD t=%0t out got %h exp %h", $time, modOut, e);
        fail_count++;
      end
    end
  end
  always @(posedge clk_sys) begin
    if ((bvalid && bready) || (rvalid && rready)) begin : bus_cmp
      logic [33:0] g, e;
      g = (bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata};
      e = (busQ.size() > 0) ? busQ.pop_front() : 34'h0;
      n_checks++;
      if (g !== e) begin
        $display("BAD t=%0t bus got %h exp %h", $time, g, e);
        fail_count++;
      end
    end
  end
  // ==========================================================================
  // Register bus master; index 5 is unmapped
  task automatic wr(input int i, input logic [7:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    busQ.push_back({(i < 5) ? cdm_pkg::RESP_OKAY : cdm_pkg::RESP_SLVERR, 32'h0});
    awaddr <= {cdm_pkg::IDX_MAIN + 14'(i), 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk_sys);
      if (awready && !a) awvalid <= 1'b0;
      if (wready && !w) wvalid <= 1'b0;
      a = a || awready;
      w = w || wready;
    end
    bready <= 1'b1;
    @(posedge clk_sys);
    // Output readback bit cannot be written
    if (i < 5) sh[i] <= (i == 0) ? (d & 8'hdf) : d;
    while (!bvalid) @(posedge clk_sys);
    bready <= 1'b0;
  endtask
  task automatic rd(input int i);
    @(posedge clk_sys);
    araddr <= {cdm_pkg::IDX_MAIN + 14'(i), 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    busQ.push_back({(i < 5) ? cdm_pkg::RESP_OKAY : cdm_pkg::RESP_SLVERR, 24'h0,
      (i == 0) ? (sh[0] | {2'b00, curOut, 5'h00}) : (i < 5) ? sh[i] : 8'h00});
    while (!rvalid) @(posedge clk_sys);
    rready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(32'h88f7));
    sh = '{default: 8'h00};
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk <= 1'b1;
    for (int r = 0; r < 6; r++) rd(r);
    wr(5, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      slow <= i[0];
      wr(4, {4'h0, 4'(i)});
      wr(3, {4'h0, ~4'(i)});
      wr(2, {3'h0, 5'(i)});
      wr(1, 8'($urandom) & 8'h33);
      wr(0, (8'($urandom) & 8'h31) | ((i < 28) ? 8'h80 : 8'h00));
      repeat (24) @(posedge clk_sys);
      for (int r = 0; r < 5; r++) rd(r);
      $display("test mix %0d done", i);
    end
    // Reserved high code inverted gives a steady high output to power down
    wr(4, 8'h0b);
    wr(1, 8'h20);
    wr(2, 8'h01);
    wr(0, 8'h81);
    rd(0);
    pd <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pd <= 1'b0;
    for (int r = 0; r < 5; r++) rd(r);
    $display("test power down done");
    complete_run();
  end
  // Budget is roughly fourteen times the planned run
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule
